/* File: src/ppc_pkg.sv */
// package of offsets, widths and reset values for the parallel port pin control block
package ppc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned PPC_ADDR_W = 3;
  localparam int unsigned PPC_DATA_W = 8;
  localparam int unsigned PPC_NARROW_W = 4;
  localparam int unsigned PPC_WIDE_W = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_NARROW_PULLUP = 3'h0;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_NARROW_SLEW = 3'h1;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_NARROW_DRIVE = 3'h2;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_WIDE_DATA = 3'h3;
  localparam logic [PPC_ADDR_W-1:0] PPC_OFF_WIDE_DIR = 3'h4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PPC_NARROW_W-1:0] PPC_RST_NARROW = 4'h0;
  localparam logic [PPC_WIDE_W-1:0] PPC_RST_WIDE_DATA = 8'h00;
  localparam logic [PPC_WIDE_W-1:0] PPC_RST_WIDE_DIR = 8'h00;
  localparam logic [PPC_DATA_W-1:0] PPC_RDATA_IDLE = 8'h00;

endpackage

/* File: src/ppc_top.sv */
// parallel port pin control: narrow port pin controls and wide port data and direction
// Contract
// - pullup bit one enables narrow pin pullup
// - narrow output pins never have pullup on
// - slew bit limits slew, outputs only
// - drive bit zero low, one high
// - input pins read sampled pin level
// - output pins read last written value
// - data write loads every latch bit
// - output pins driven from latch
// - reset clears latch, pins stay inputs
// - direction zero input, one drives latch
// - eight direction bits, one per pin
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ppc_top
  import ppc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [PPC_ADDR_W-1:0] i_addr,
  input wire logic [PPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [PPC_DATA_W-1:0] o_rdata,
  input wire logic [PPC_NARROW_W-1:0] i_narrow_port_dir,
  output logic [PPC_NARROW_W-1:0] o_narrow_port_pullup_en,
  output logic [PPC_NARROW_W-1:0] o_narrow_port_slew_en,
  output logic [PPC_NARROW_W-1:0] o_narrow_port_drive_high,
  input wire logic [PPC_WIDE_W-1:0] i_wide_port_pin,
  output logic [PPC_WIDE_W-1:0] o_wide_port_pin_out,
  output logic [PPC_WIDE_W-1:0] o_wide_port_pin_oe
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [PPC_NARROW_W-1:0] pullup_q;
  logic [PPC_NARROW_W-1:0] pullup_d;
  logic [PPC_NARROW_W-1:0] slew_q;
  logic [PPC_NARROW_W-1:0] slew_d;
  logic [PPC_NARROW_W-1:0] drive_q;
  logic [PPC_NARROW_W-1:0] drive_d;
  logic [PPC_WIDE_W-1:0] latch_q;
  logic [PPC_WIDE_W-1:0] latch_d;
  logic [PPC_WIDE_W-1:0] dir_q;
  logic [PPC_WIDE_W-1:0] dir_d;
  logic [PPC_DATA_W-1:0] rdata_q;
  logic [PPC_DATA_W-1:0] rdata_d;

  // ----------------------------------------------------------------
  // bus decode and pin control nets
  // ----------------------------------------------------------------
  logic wr_pullup;
  logic wr_slew;
  logic wr_drive;
  logic wr_latch;
  logic wr_dir;
  logic rd_pullup;
  logic rd_slew;
  logic rd_drive;
  logic rd_latch;
  logic rd_dir;
  logic [PPC_NARROW_W-1:0] pullup_en_c;
  logic [PPC_NARROW_W-1:0] slew_en_c;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // true when the bus address selects the register at this offset
  function automatic logic reg_hit(
    input logic [PPC_ADDR_W-1:0] addr,
    input logic [PPC_ADDR_W-1:0] offset
  );
    reg_hit = (addr == offset);
  endfunction

  // narrow register padded to bus width, upper bits zero
  function automatic logic [PPC_DATA_W-1:0] pad_narrow(input logic [PPC_NARROW_W-1:0] v);
    pad_narrow = {{(PPC_DATA_W-PPC_NARROW_W){1'b0}}, v};
  endfunction

  // implemented bits of a bus word for a narrow register
  function automatic logic [PPC_NARROW_W-1:0] narrow_field(input logic [PPC_DATA_W-1:0] w);
    narrow_field = w[PPC_NARROW_W-1:0];
  endfunction

  // per bit: latch for output pins, pin level for input pins
  function automatic logic [PPC_WIDE_W-1:0] wide_read_mix(
    input logic [PPC_WIDE_W-1:0] dir,
    input logic [PPC_WIDE_W-1:0] latch,
    input logic [PPC_WIDE_W-1:0] pin
  );
    wide_read_mix = (dir & latch) | (~dir & pin);
  endfunction

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // one-hot write strobes, unmapped offsets select nothing
  always_comb begin
    wr_pullup = 1'b0;
    wr_slew = 1'b0;
    wr_drive = 1'b0;
    wr_latch = 1'b0;
    wr_dir = 1'b0;
    if (i_wr) begin
      if (reg_hit(i_addr, PPC_OFF_NARROW_PULLUP)) begin
        wr_pullup = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_NARROW_SLEW)) begin
        wr_slew = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_NARROW_DRIVE)) begin
        wr_drive = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_WIDE_DATA)) begin
        wr_latch = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_WIDE_DIR)) begin
        wr_dir = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_pullup = 1'b0;
    rd_slew = 1'b0;
    rd_drive = 1'b0;
    rd_latch = 1'b0;
    rd_dir = 1'b0;
    if (i_rd) begin
      if (reg_hit(i_addr, PPC_OFF_NARROW_PULLUP)) begin
        rd_pullup = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_NARROW_SLEW)) begin
        rd_slew = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_NARROW_DRIVE)) begin
        rd_drive = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_WIDE_DATA)) begin
        rd_latch = 1'b1;
      end else if (reg_hit(i_addr, PPC_OFF_WIDE_DIR)) begin
        rd_dir = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // narrow port pullup enable register
  // ----------------------------------------------------------------
  // stored whatever the pin direction, gated at the pin below
  always_comb begin
    pullup_d = pullup_q;
    if (wr_pullup) begin
      pullup_d = narrow_field(i_wdata);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pullup_q <= PPC_RST_NARROW;
    end else begin
      pullup_q <= pullup_d;
    end
  end

  // ----------------------------------------------------------------
  // narrow port slew enable register
  // ----------------------------------------------------------------
  // stored even while the pin is an input
  always_comb begin
    slew_d = slew_q;
    if (wr_slew) begin
      slew_d = narrow_field(i_wdata);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      slew_q <= PPC_RST_NARROW;
    end else begin
      slew_q <= slew_d;
    end
  end

  // ----------------------------------------------------------------
  // narrow port drive select register
  // ----------------------------------------------------------------
  // zero selects low drive, one high drive
  always_comb begin
    drive_d = drive_q;
    if (wr_drive) begin
      drive_d = narrow_field(i_wdata);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      drive_q <= PPC_RST_NARROW;
    end else begin
      drive_q <= drive_d;
    end
  end

  // ----------------------------------------------------------------
  // wide port data latch
  // ----------------------------------------------------------------
  // input pins load too, so the value shows once turned to output
  always_comb begin
    latch_d = latch_q;
    if (wr_latch) begin
      latch_d = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      latch_q <= PPC_RST_WIDE_DATA;
    end else begin
      latch_q <= latch_d;
    end
  end

  // ----------------------------------------------------------------
  // wide port direction register
  // ----------------------------------------------------------------
  // one bit per pin, every pin an input after reset
  always_comb begin
    dir_d = dir_q;
    if (wr_dir) begin
      dir_d = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      dir_q <= PPC_RST_WIDE_DIR;
    end else begin
      dir_q <= dir_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // idle value between reads so the bus sees zero
  always_comb begin
    rdata_d = PPC_RDATA_IDLE;
    if (rd_pullup) begin
      rdata_d = pad_narrow(pullup_q);
    end else if (rd_slew) begin
      rdata_d = pad_narrow(slew_q);
    end else if (rd_drive) begin
      rdata_d = pad_narrow(drive_q);
    end else if (rd_latch) begin
      rdata_d = wide_read_mix(dir_q, latch_q, i_wide_port_pin);
    end else if (rd_dir) begin
      rdata_d = dir_q;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_q <= PPC_RDATA_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // read data output
  // ----------------------------------------------------------------
  assign o_rdata = rdata_q;

  // ----------------------------------------------------------------
  // narrow port pin controls
  // ----------------------------------------------------------------
  // output pins lose the pullup, input pins ignore slew
  always_comb begin
    pullup_en_c = {PPC_NARROW_W{1'b0}};
    slew_en_c = {PPC_NARROW_W{1'b0}};
    for (int unsigned i = 0; i < PPC_NARROW_W; i++) begin
      if (i_narrow_port_dir[i]) begin
        pullup_en_c[i] = 1'b0;
        slew_en_c[i] = slew_q[i];
      end else begin
        pullup_en_c[i] = pullup_q[i];
        slew_en_c[i] = 1'b0;
      end
    end
  end

  assign o_narrow_port_pullup_en = pullup_en_c;
  assign o_narrow_port_slew_en = slew_en_c;
  assign o_narrow_port_drive_high = drive_q;

  // ----------------------------------------------------------------
  // wide port pin drive
  // ----------------------------------------------------------------
  assign o_wide_port_pin_out = latch_q;
  assign o_wide_port_pin_oe = dir_q;

endmodule

`default_nettype wire

/* File: testbench/ppc_pins.sv */
// pin model
`timescale 1ns/10ps
`default_nettype none
module ppc_pins (input wire logic [7:0] i_out, i_oe, output logic [7:0] o_pin);
  assign o_pin = i_out & i_oe | 8'h3c & ~i_oe;
endmodule
`default_nettype wire

/* File: testbench/ppc_chk.sv */
// port checker
`timescale 1ns/10ps
`default_nettype none
module ppc_chk (
  input wire logic i_sys_clk, i_rst, i_wr, i_rd,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata, o_rdata, i_wide_port_pin, o_wide_port_pin_out, o_wide_port_pin_oe,
  input wire logic [3:0] i_narrow_port_dir, o_narrow_port_pullup_en, o_narrow_port_slew_en, o_narrow_port_drive_high
);
  wire logic [7:0] rd_mix = (o_wide_port_pin_oe & o_wide_port_pin_out) | (~o_wide_port_pin_oe & i_wide_port_pin);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_pullup_off: assert property ((o_narrow_port_pullup_en & i_narrow_port_dir) == 4'h0) else $error("pullup");
  a_slew_off: assert property ((o_narrow_port_slew_en & ~i_narrow_port_dir) == 4'h0) else $error("slew");
  a_pins_reset: assert property ($fell(i_rst) |-> o_wide_port_pin_oe == 8'h00) else $error("reset");
  a_latch_wr: assert property (i_wr && i_addr == 3'h3 |=>
    o_wide_port_pin_out == $past(i_wdata)) else $error("latch");
  a_dir_wr: assert property (i_wr && i_addr == 3'h4 |=>
    o_wide_port_pin_oe == $past(i_wdata)) else $error("dir");
  a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("idle");
  a_wide_rd: assert property (i_rd && i_addr == 3'h3 |=>
    o_rdata == $past(rd_mix)) else $error("wide read");
  a_narrow_rd: assert property (i_rd && i_addr < 3'h3 |=> o_rdata[7:4] == 4'h0) else $error("narrow");
  a_drive_keep: assert property (!(i_wr && i_addr == 3'h2) |=>
    $stable(o_narrow_port_drive_high)) else $error("drive");
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [2:0] a = 3'h0;
  logic [3:0] nd = 4'h3, pu, sl, ds;
  logic [7:0] wd = 8'h00, q, po, oe, pin;
  int fails = 0, checks = 0;
  always #10 clk = ~clk;
  ppc_top dut_u (.i_sys_clk(clk), .i_rst(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(q),
    .i_narrow_port_dir(nd), .o_narrow_port_pullup_en(pu), .o_narrow_port_slew_en(sl),
    .o_narrow_port_drive_high(ds), .i_wide_port_pin(pin), .o_wide_port_pin_out(po), .o_wide_port_pin_oe(oe));
  ppc_pins pins_u (.i_out(po), .i_oe(oe), .o_pin(pin));
  task chk(string n, logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task acc(logic w, logic [2:0] ad, logic [7:0] d);
    @(posedge clk);
    {wr, rd, a, wd} <= {w, !w, ad, d};
    @(posedge clk);
    {wr, rd} <= 2'h0;
    #1;
  endtask
  task s_narrow;
    acc(1'b1, 3'h0, 8'h0f);
    acc(1'b1, 3'h1, 8'h0f);
    acc(1'b1, 3'h2, 8'h05);
    chk("pullup slew", {pu, sl}, 8'hc3);
    chk("drive", {4'h0, ds}, 8'h05);
    acc(1'b0, 3'h2, 8'h00);
    chk("drive read", q, 8'h05);
    @(posedge clk);
    nd <= 4'hc;
    #1;
    chk("pullup slew swap", {pu, sl}, 8'h3c);
  endtask
  task s_wide;
    chk("pins idle", oe | po, 8'h00);
    acc(1'b1, 3'h3, 8'ha5);
    chk("latch", po, 8'ha5);
    acc(1'b0, 3'h3, 8'h00);
    chk("input read", q, 8'h3c);
    acc(1'b1, 3'h4, 8'h0f);
    chk("pins", pin, 8'h35);
    acc(1'b0, 3'h3, 8'h00);
    chk("output read", q, 8'h35);
    acc(1'b1, 3'h4, 8'hf0);
    chk("pins upper", pin, 8'hac);
    acc(1'b0, 3'h4, 8'h00);
    chk("dir read", q, 8'hf0);
  endtask
  task s_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("reset pins", oe | po, 8'h00);
    chk("reset pin level", pin, 8'h3c);
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    s_wide;
    s_reset;
    s_narrow;
    give_verdict;
  end
  initial begin
    #4000;
    fails++;
    give_verdict;
  end
endmodule
bind ppc_top ppc_chk chk_u (.*);
`default_nettype wire
